// >>> design/pesd_pkg.sv
package pesd_pkg;
	// event codes
	localparam logic [7:0] EVT_RESOURCE_STALLS = 8'ha2;
	localparam logic [7:0] EVT_MISS_ACTIVITY = 8'ha3;
	localparam logic [7:0] EVT_PORT_ACTIVITY = 8'ha6;
	localparam logic [7:0] EVT_LOOP_STREAM = 8'ha8;
	localparam logic [7:0] EVT_UOP_CACHE_SWITCH = 8'hab;
	localparam logic [7:0] EVT_ITB_FLUSH = 8'hae;
	localparam logic [7:0] EVT_OFFCORE_REQ = 8'hb0;
	// unit masks
	localparam logic [7:0] UM_ANY_STALL = 8'h01;
	localparam logic [7:0] UM_SB_STALL = 8'h08;
	localparam logic [7:0] UM_L2_MISS = 8'h01;
	localparam logic [7:0] UM_L3_MISS = 8'h02;
	localparam logic [7:0] UM_STALLS_TOTAL = 8'h04;
	localparam logic [7:0] UM_L1D_MISS = 8'h08;
	localparam logic [7:0] UM_MEM_ANY = 8'h10;
	localparam logic [7:0] UM_EXE_STALL = 8'h04;
	localparam logic [7:0] UM_PORTS_0 = 8'h01;
	localparam logic [7:0] UM_PORTS_1 = 8'h02;
	localparam logic [7:0] UM_PORTS_2 = 8'h04;
	localparam logic [7:0] UM_PORTS_3 = 8'h08;
	localparam logic [7:0] UM_PORTS_4 = 8'h20;
	localparam logic [7:0] UM_BOUND_STORES = 8'h40;
	localparam logic [7:0] UM_LSB_UOPS = 8'h01;
	localparam logic [7:0] UM_SWITCH_PENALTY = 8'h02;
	localparam logic [7:0] UM_ITB_FLUSH = 8'h01;
	localparam logic [7:0] UM_DEMAND_DATA_RD = 8'h01;
	localparam logic [7:0] UM_DEMAND_CODE_RD = 8'h02;
	// widths
	localparam int CNT_W = 48;
	localparam int INC_W = 5;
	localparam logic [CNT_W-1:0] CNT_RESET = 48'h0;
	localparam logic [INC_W-1:0] INC_ZERO = 5'h00;
	localparam logic [2:0] FOUR_UOPS = 3'h4;
	typedef logic [INC_W-1:0] pesd_inc_t;
endpackage

// >>> design/pesd_cond_sel.sv
`timescale 1ns/1ps
// picks the per-cycle occurrence count for an event code / unit mask pair
module pesd_cond_sel
	import pesd_pkg::*;
(
	// selection
	input wire logic [7:0] evt_code,
	input wire logic [7:0] unit_mask,
	// conditions
	input wire logic sb_full_stall,
	input wire logic any_resource_stall,
	input wire logic exe_stall,
	input wire logic l1d_miss_out,
	input wire logic l2_miss_out,
	input wire logic l3_miss_out,
	input wire logic mem_load_out,
	input wire logic rs_nonempty,
	input wire logic sb_full,
	input wire logic [2:0] uops_started,
	input wire logic [2:0] lsb_uops,
	input wire logic [2:0] dec_uops,
	input wire logic switch_penalty,
	input wire logic itb_flush,
	input wire logic [1:0] data_rd_req,
	input wire logic [1:0] code_rd_req,
	// result
	output pesd_inc_t occ,
	output logic valid_sel
);
	logic [4:0] miss_bits;
	logic [4:0] miss_hit;
	// unit mask bits of the miss-activity event are and-ed conditions
	assign miss_bits = {mem_load_out, l1d_miss_out, exe_stall, l3_miss_out, l2_miss_out};

	// one gate per mask bit; the matched bits read as a number
	for (genvar i = 0; i < 5; i++) begin : g_miss
		assign miss_hit[i] = unit_mask[i] & miss_bits[i];
	end

	// one-hot-ish condition sum; miss-activity sums matched bit weights
	always_comb begin
		occ = INC_ZERO;
		valid_sel = 1'b1;
		case (evt_code)
		EVT_RESOURCE_STALLS: begin
			if (unit_mask == UM_SB_STALL)
				occ = {4'h0, sb_full_stall};
			else if (unit_mask == UM_ANY_STALL)
				occ = {4'h0, any_resource_stall};
			else
				valid_sel = 1'b0;
		end
		EVT_MISS_ACTIVITY: begin
			// sum of matched bit weights, so threshold equal to mask gives the and
			occ = miss_hit;
			if (unit_mask[7:5] != 3'h0 || unit_mask[4:0] == 5'h00)
				valid_sel = 1'b0;
		end
		EVT_PORT_ACTIVITY: begin
			case (unit_mask)
			UM_PORTS_0: occ = {4'h0, uops_started == 3'h0 && rs_nonempty && sb_full && !mem_load_out};
			UM_PORTS_1: occ = {4'h0, uops_started == 3'h1 && rs_nonempty};
			// 04h would mean both 2 and 4 uops; 04h keeps 2, 4 moved to 20h
			UM_PORTS_2: occ = {4'h0, uops_started == 3'h2 && rs_nonempty};
			UM_PORTS_3: occ = {4'h0, uops_started == 3'h3 && rs_nonempty};
			UM_PORTS_4: occ = {4'h0, uops_started >= FOUR_UOPS && rs_nonempty};
			UM_BOUND_STORES: occ = {4'h0, sb_full && !mem_load_out};
			default: valid_sel = 1'b0;
			endcase
		end
		EVT_LOOP_STREAM: begin
			// only-lsb cycles for the threshold path; the raw sum bypasses this at the top
			if (unit_mask == UM_LSB_UOPS)
				occ = (dec_uops == 3'h0) ? {2'h0, lsb_uops} : INC_ZERO;
			else
				valid_sel = 1'b0;
		end
		EVT_UOP_CACHE_SWITCH: begin
			if (unit_mask == UM_SWITCH_PENALTY)
				occ = {4'h0, switch_penalty};
			else
				valid_sel = 1'b0;
		end
		EVT_ITB_FLUSH: begin
			if (unit_mask == UM_ITB_FLUSH)
				occ = {4'h0, itb_flush};
			else
				valid_sel = 1'b0;
		end
		EVT_OFFCORE_REQ: begin
			if (unit_mask == UM_DEMAND_DATA_RD)
				occ = {3'h0, data_rd_req};
			else if (unit_mask == UM_DEMAND_CODE_RD)
				occ = {3'h0, code_rd_req};
			else
				valid_sel = 1'b0;
		end
		default: valid_sel = 1'b0;
		endcase
	end
endmodule // pesd_cond_sel

// >>> design/pesd_thresh.sv
`timescale 1ns/1ps
// threshold compare: nonzero threshold gives 0/1 per cycle
module pesd_thresh
	import pesd_pkg::*;
(
	// in
	input wire logic [7:0] threshold,
	input wire pesd_inc_t occ,
	// out
	output pesd_inc_t inc
);
	// occurrence count is narrow, so compare at threshold width
	always_comb begin
		if (threshold == 8'h00)
			inc = occ;
		else if ({3'h0, occ} >= threshold)
			inc = INC_W'(1);
		else
			inc = INC_ZERO;
	end
endmodule // pesd_thresh

// >>> design/pesd_core_event_sel.sv
`timescale 1ns/1ps
module pesd_core_event_sel
	import pesd_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// selection, from core logic on the same clock
	input wire logic COUNT_EN,
	input wire logic [7:0] EVENT_CODE,
	input wire logic [7:0] UNIT_MASK,
	input wire logic [7:0] THRESHOLD,
	input wire logic COUNT_CLEAR,
	// microarchitectural conditions
	input wire logic SB_FULL_STALL,
	input wire logic ANY_RESOURCE_STALL,
	input wire logic EXE_STALL,
	input wire logic L1D_MISS_OUT,
	input wire logic L2_MISS_OUT,
	input wire logic L3_MISS_OUT,
	input wire logic MEM_LOAD_OUT,
	input wire logic RS_NONEMPTY,
	input wire logic SB_FULL,
	input wire logic [2:0] UOPS_STARTED,
	input wire logic [2:0] LOOP_STREAM_BUFFER_UOPS,
	input wire logic [2:0] DECODER_UOPS,
	input wire logic SWITCH_PENALTY,
	input wire logic ITB_FLUSH,
	input wire logic [1:0] DEMAND_DATA_RD,
	input wire logic [1:0] DEMAND_CODE_RD,
	// result
	output logic [pesd_pkg::CNT_W-1:0] EVENT_COUNT,
	output logic SELECT_VALID
);
	import pesd_pkg::*;

	pesd_inc_t occ;
	pesd_inc_t inc;
	logic valid_sel;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic valid_r;
	logic valid_nxt;
	pesd_inc_t occ_thr;
	logic lsb_raw;

	// decode of the selected condition
	pesd_cond_sel u_sel (
		.evt_code(EVENT_CODE),
		.unit_mask(UNIT_MASK),
		.sb_full_stall(SB_FULL_STALL),
		.any_resource_stall(ANY_RESOURCE_STALL),
		.exe_stall(EXE_STALL),
		.l1d_miss_out(L1D_MISS_OUT),
		.l2_miss_out(L2_MISS_OUT),
		.l3_miss_out(L3_MISS_OUT),
		.mem_load_out(MEM_LOAD_OUT),
		.rs_nonempty(RS_NONEMPTY),
		.sb_full(SB_FULL),
		.uops_started(UOPS_STARTED),
		.lsb_uops(LOOP_STREAM_BUFFER_UOPS),
		.dec_uops(DECODER_UOPS),
		.switch_penalty(SWITCH_PENALTY),
		.itb_flush(ITB_FLUSH),
		.data_rd_req(DEMAND_DATA_RD),
		.code_rd_req(DEMAND_CODE_RD),
		.occ(occ),
		.valid_sel(valid_sel)
	);

	// raw loop buffer sum ignores the decoder; only the cycle counts need it idle
	assign lsb_raw = EVENT_CODE == EVT_LOOP_STREAM && UNIT_MASK == UM_LSB_UOPS && THRESHOLD == 8'h00;
	assign occ_thr = lsb_raw ? {2'h0, LOOP_STREAM_BUFFER_UOPS} : occ;

	// threshold stage
	pesd_thresh u_thr (
		.threshold(THRESHOLD),
		.occ(occ_thr),
		.inc(inc)
	);

	// next count; clear wins, unknown selections count nothing
	always_comb begin
		count_nxt = count_r;
		valid_nxt = valid_sel;
		if (COUNT_CLEAR)
			count_nxt = CNT_RESET;
		else if (COUNT_EN && valid_sel)
			count_nxt = count_r + CNT_W'(inc);
	end

	// counter registers, wraps silently; no overflow flag is kept
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			count_r <= CNT_RESET;
			valid_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign EVENT_COUNT = count_r;
	assign SELECT_VALID = valid_r;
endmodule // pesd_core_event_sel

// >>> testbench/pesd_core_event_sel_sva.sv
`timescale 1ns/1ps
module pesd_core_event_sel_sva
	import pesd_pkg::*;
(
	// clock and control
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic COUNT_EN,
	input wire logic COUNT_CLEAR,
	input wire logic [7:0] EVENT_CODE,
	input wire logic [7:0] UNIT_MASK,
	input wire logic [7:0] THRESHOLD,
	// watched conditions and result
	input wire logic SB_FULL_STALL,
	input wire logic ITB_FLUSH,
	input wire logic SWITCH_PENALTY,
	input wire logic [pesd_pkg::CNT_W-1:0] EVENT_COUNT,
	input wire logic SELECT_VALID
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	// raw counting this cycle, no threshold applied
	wire logic raw = COUNT_EN && !COUNT_CLEAR && THRESHOLD == 8'h00;
	wire logic [15:0] sel = {EVENT_CODE, UNIT_MASK};
	chk_clear_zero: assert property (COUNT_CLEAR |=> EVENT_COUNT == '0) else $error("clear missed");
	chk_hold_idle: assert property (!COUNT_EN && !COUNT_CLEAR |=> $stable(EVENT_COUNT)) else $error("idle move");
	chk_sb_stall: assert property (raw && sel == 16'ha208 |=>
		EVENT_COUNT == $past(EVENT_COUNT) + $past(SB_FULL_STALL)) else $error("store stall count");
	chk_switch_pen: assert property (raw && sel == 16'hab02 |=>
		EVENT_COUNT == $past(EVENT_COUNT) + $past(SWITCH_PENALTY)) else $error("switch count");
	chk_itb_flush: assert property (raw && sel == 16'hae01 |=>
		EVENT_COUNT == $past(EVENT_COUNT) + $past(ITB_FLUSH)) else $error("flush count");
	chk_thresh_step: assert property (COUNT_EN && !COUNT_CLEAR && THRESHOLD != 8'h00 |=>
		EVENT_COUNT - $past(EVENT_COUNT) <= 48'h1) else $error("threshold step above one");
	chk_valid_known: assert property (sel == 16'ha208 |=> SELECT_VALID) else $error("valid low");
	chk_valid_unknown: assert property (EVENT_CODE == 8'h00 |=> !SELECT_VALID) else $error("valid high");
	// main scenarios reached
	cover property (COUNT_EN && sel == 16'ha30c && THRESHOLD == 8'h0c);
	cover property (raw && sel == 16'ha208 && SB_FULL_STALL);
	cover property (COUNT_CLEAR && EVENT_COUNT != '0);
endmodule // pesd_core_event_sel_sva

bind pesd_core_event_sel pesd_core_event_sel_sva u_sva (.*);

// >>> testbench/pesd_core_event_sel_tb_top.sv
`timescale 1ns/1ps
module pesd_core_event_sel_tb_top;
	import pesd_pkg::*;
	logic SYS_CLK, RESET, COUNT_EN, COUNT_CLEAR, SB_FULL_STALL, ANY_RESOURCE_STALL;
	logic SWITCH_PENALTY, ITB_FLUSH, RS_NONEMPTY, SB_FULL, SELECT_VALID;
	logic [4:0] miss; // mem, l1d, exe stall, l3, l2
	logic [7:0] EVENT_CODE, UNIT_MASK, THRESHOLD;
	logic [2:0] UOPS_STARTED, LOOP_STREAM_BUFFER_UOPS, DECODER_UOPS;
	logic [1:0] DEMAND_DATA_RD, DEMAND_CODE_RD;
	logic [CNT_W-1:0] EVENT_COUNT;
	int fail_count = 0;
	int num_checks = 0;
	pesd_core_event_sel uut (.*, .EXE_STALL(miss[2]), .L1D_MISS_OUT(miss[3]), .L2_MISS_OUT(miss[0]),
		.L3_MISS_OUT(miss[1]), .MEM_LOAD_OUT(miss[4]));
	// 200 MHz core clock
	initial begin
		SYS_CLK = 1'b0;
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end
	// inputs move 1 ns after the edge so sampling never races
	task automatic tick;
		@(posedge SYS_CLK) #1;
	endtask
	task automatic quiet;
		{SB_FULL_STALL, ANY_RESOURCE_STALL, SWITCH_PENALTY, ITB_FLUSH, RS_NONEMPTY, SB_FULL} = 6'h00;
		{miss, UOPS_STARTED, LOOP_STREAM_BUFFER_UOPS, DECODER_UOPS, DEMAND_DATA_RD, DEMAND_CODE_RD} = 18'h0;
	endtask
	// new selection with a one-cycle clear, counting from the next edge
	task automatic sel(input logic [7:0] c, m, t);
		quiet();
		{EVENT_CODE, UNIT_MASK, THRESHOLD} = {c, m, t};
		{COUNT_CLEAR, COUNT_EN} = 2'h3;
		tick();
		COUNT_CLEAR = 1'b0;
	endtask
	task automatic cmp_cnt(input logic [CNT_W-1:0] e, g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t count %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic cmp_v(input logic e, g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t select valid %b expected %b", $time, g, e);
		end
	endtask
	// stop counting, let the last edge land, then judge
	task automatic fin(input logic [CNT_W-1:0] e, input logic v);
		quiet();
		COUNT_EN = 1'b0;
		tick();
		cmp_cnt(e, EVENT_COUNT);
		cmp_v(v, SELECT_VALID);
	endtask
	// same two cycles under every plain selection; store stall drops out in the second
	task automatic t_plain;
		logic [15:0] s [7] = '{16'ha208, 16'ha201, 16'hab02, 16'hae01, 16'hb001, 16'hb002, 16'h0001};
		logic [3:0] e [7] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h6, 4'h2, 4'h0};
		foreach (s[i]) begin
			sel(s[i][15:8], s[i][7:0], 8'h00);
			{SB_FULL_STALL, ANY_RESOURCE_STALL, SWITCH_PENALTY, ITB_FLUSH} = 4'hf;
			{DEMAND_DATA_RD, DEMAND_CODE_RD} = 4'hd;
			tick();
			SB_FULL_STALL = 1'b0;
			tick();
			fin(e[i], i < 6);
		end
	endtask
	// one masked condition missing must not count, all present must
	task automatic t_miss;
		logic [7:0] m [9] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h14};
		foreach (m[i]) begin
			sel(8'ha3, m[i], m[i]);
			miss = 5'h1f ^ (m[i][4:0] & -m[i][4:0]);
			repeat (2) tick();
			miss = 5'h1f;
			repeat (2) tick();
			fin(48'h2, 1'b1);
		end
	endtask
	// sweep 0..4 started uops; each utilisation mask matches exactly one
	task automatic t_ports;
		logic [7:0] m [4] = '{8'h02, 8'h04, 8'h08, 8'h20};
		logic [7:0] b [2] = '{8'h01, 8'h40};
		foreach (m[i]) begin
			sel(8'ha6, m[i], 8'h00);
			RS_NONEMPTY = 1'b1;
			for (int u = 0; u < 5; u++) begin
				UOPS_STARTED = u[2:0];
				tick();
			end
			fin(48'h1, 1'b1);
		end
		foreach (b[i]) begin
			sel(8'ha6, b[i], 8'h00);
			{RS_NONEMPTY, SB_FULL} = 2'h3;
			tick();
			miss[4] = 1'b1;
			tick();
			fin(48'h1, 1'b1);
		end
	endtask
	// loop buffer uops: raw sum, then cycle counts at threshold one and four
	task automatic t_lsb;
		logic [7:0] t [3] = '{8'h00, 8'h01, 8'h04};
		logic [3:0] e [3] = '{4'hb, 4'h2, 4'h1};
		foreach (t[i]) begin
			sel(8'ha8, 8'h01, t[i]);
			LOOP_STREAM_BUFFER_UOPS = 3'h3;
			tick();
			LOOP_STREAM_BUFFER_UOPS = 3'h4;
			tick();
			DECODER_UOPS = 3'h1;
			tick();
			fin(e[i], 1'b1);
		end
	endtask
	// reset in mid-count zeroes the counter and the valid flag, counting resumes after
	task automatic t_reset;
		sel(8'ha2, 8'h08, 8'h00);
		SB_FULL_STALL = 1'h1;
		repeat (2) tick();
		RESET = 1'h1;
		tick();
		cmp_cnt(48'h0, EVENT_COUNT);
		cmp_v(1'h0, SELECT_VALID);
		RESET = 1'h0;
		tick();
		fin(48'h1, 1'h1);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// reset for six cycles, then the scenarios
	initial begin
		{RESET, COUNT_EN, COUNT_CLEAR} = 3'h4;
		{EVENT_CODE, UNIT_MASK, THRESHOLD} = 24'h0;
		quiet();
		repeat (6) tick();
		RESET = 1'b0;
		cmp_cnt(48'h0, EVENT_COUNT);
		cmp_v(1'h0, SELECT_VALID);
		t_plain();
		t_miss();
		t_ports();
		t_lsb();
		t_reset();
		end_sim();
	end
	// watchdog: the run needs 145 cycles
	initial begin
		#20000;
		fail_count++;
		end_sim();
	end
endmodule // pesd_core_event_sel_tb_top
